// ### include/spi_ctl_pkg.sv
/*
 * Constants shared by the width and pin control block and its link engine:
 * register offsets, field positions, masks, reset values and link states.
 * Assumes a byte-wide register port with a three-bit address.
 */
package spi_ctl_pkg;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [2:0] OFF_CTRL_ONE = 3'h0;
	localparam logic [2:0] OFF_CTRL_TWO = 3'h1;
	localparam logic [2:0] OFF_BAUD = 3'h2;
	localparam logic [2:0] OFF_STATUS = 3'h3;
	localparam logic [2:0] OFF_DATA_HI = 3'h4;
	localparam logic [2:0] OFF_DATA_LO = 3'h5;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int C1_ENABLE = 6;
	localparam int C1_MASTER = 4;
	localparam int C1_SELECT_OUTPUT_EN = 1;
	localparam int C2_WIDTH = 6;
	localparam int C2_FAULT = 4;
	localparam int C2_OE = 3;
	localparam int C2_WAIT = 1;
	localparam int C2_BIDIR = 0;
	localparam int ST_DONE = 7;
	localparam int ST_EMPTY = 5;
	localparam int ST_FAULT = 4;

	// ------------------------------------------------------------
	// Masks and reset values
	// ------------------------------------------------------------
	localparam logic [7:0] C2_IMPL_MASK = 8'h5b;
	localparam logic [7:0] C2_ABORT_MASK = 8'h51;
	localparam logic [7:0] C2_OE_MASK = 8'h08;
	localparam logic [7:0] C1_MASTER_MASK = 8'h10;
	localparam logic [7:0] C1_SELECT_OUTPUT_EN_MASK = 8'h02;
	localparam logic [7:0] C1_ENABLE_MASK = 8'h40;
	localparam logic [7:0] CTRL_ONE_RST = 8'h00;
	localparam logic [7:0] CTRL_TWO_RST = 8'h00;

	// ------------------------------------------------------------
	// Transfer lengths and link states
	// ------------------------------------------------------------
	localparam logic [4:0] BITS_NARROW = 5'h08;
	localparam logic [4:0] BITS_WIDE = 5'h10;

	typedef enum logic [1:0] {
		LINK_IDLE = 2'b01,
		LINK_SHIFT = 2'b10
	} link_state_t;

endpackage

// ### hw/spi_link_engine.sv
/*
 * Shift engine on the link clock: synchronises control toggles and pins,
 * shifts 8 or 16 bits MSB first, reports completion and abort by toggles.
 * Assumes tx_word and the config levels stay still while a word is shifted.
 */
`timescale 1ns/1ps

module spi_link_engine (
	input wire logic link_clk, // Link clock
	input wire logic rst_b, // Async reset, active low
	input wire logic start_tgl, // Start event toggle, core domain
	input wire logic abort_tgl, // Abort event toggle, core domain
	input wire logic run_lvl, // Serial clock may run
	input wire logic cfg_master, // Master mode level
	input wire logic cfg_bidir, // Single-wire pin mode level
	input wire logic cfg_wide, // 16-bit width level
	input wire logic [15:0] tx_word, // Word to send
	input wire logic mosi_in, // MOSI pin level
	input wire logic miso_in, // MISO pin level
	input wire logic sck_in, // SCK pin level
	input wire logic ss_in, // Slave select pin level
	output logic done_tgl, // Word finished toggle
	output logic abort_ack_tgl, // Abort taken toggle
	output logic [15:0] rx_word, // Last word received
	output logic sdo, // Serial data out
	output logic sck_out // Serial clock out in master mode
);

	// ------------------------------------------------------------
	// Synchronisers
	// ------------------------------------------------------------
	logic [9:0] meta_q;
	logic [9:0] sync_q;
	logic start_seen_q;
	logic abort_seen_q;
	logic sck_prev_q;
	logic phase_q;
	logic tail_q;

	always_ff @(posedge link_clk or negedge rst_b) begin
		if (!rst_b) begin
			// Idle levels: clock may run, select high
			meta_q <= 10'h081;
			sync_q <= 10'h081;
			start_seen_q <= 1'b0;
			abort_seen_q <= 1'b0;
			sck_prev_q <= 1'b0;
		end else begin
			meta_q <= {start_tgl, abort_tgl, run_lvl, cfg_master, cfg_bidir, cfg_wide,
				mosi_in, miso_in, sck_in, ss_in};
			sync_q <= meta_q;
			start_seen_q <= sync_q[9];
			abort_seen_q <= sync_q[8];
			sck_prev_q <= sync_q[1];
		end
	end

	logic start_evt;
	logic abort_evt;
	logic run_s;
	logic mst_s;
	logic bid_s;
	logic wide_s;
	logic sck_s;
	logic ss_s;
	logic din;
	logic samp;
	logic shft;

	assign start_evt = sync_q[9] ^ start_seen_q;
	assign abort_evt = sync_q[8] ^ abort_seen_q;
	assign run_s = sync_q[7];
	assign mst_s = sync_q[6];
	assign bid_s = sync_q[5];
	assign wide_s = sync_q[4];
	assign sck_s = sync_q[1];
	assign ss_s = sync_q[0];
	assign din = mst_s ? (bid_s ? sync_q[3] : sync_q[2]) : (bid_s ? sync_q[2] : sync_q[3]);
	assign samp = mst_s ? (run_s && !phase_q) : (sck_s && !sck_prev_q);
	assign shft = mst_s ? (run_s && phase_q) : (!sck_s && sck_prev_q);

	// ------------------------------------------------------------
	// Shifter
	// ------------------------------------------------------------
	spi_ctl_pkg::link_state_t state_q;
	logic [15:0] sh_q;
	logic [4:0] cnt_q;
	logic bit_q;

	always_ff @(posedge link_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= spi_ctl_pkg::LINK_IDLE;
			sh_q <= 16'h0000;
			cnt_q <= 5'h00;
			phase_q <= 1'b0;
			bit_q <= 1'b0;
			tail_q <= 1'b0;
			sdo <= 1'b0;
			sck_out <= 1'b0;
			done_tgl <= 1'b0;
			abort_ack_tgl <= 1'b0;
			rx_word <= 16'h0000;
		end else if (abort_evt) begin
			state_q <= spi_ctl_pkg::LINK_IDLE;
			phase_q <= 1'b0;
			sck_out <= 1'b0;
			tail_q <= 1'b0;
			abort_ack_tgl <= ~abort_ack_tgl;
		end else begin
			unique case (state_q)
				spi_ctl_pkg::LINK_IDLE: begin
					if ((mst_s && start_evt) || (!mst_s && !ss_s)) begin
						sh_q <= wide_s ? tx_word : {tx_word[7:0], 8'h00};
						sdo <= wide_s ? tx_word[15] : tx_word[7];
						cnt_q <= wide_s ? spi_ctl_pkg::BITS_WIDE : spi_ctl_pkg::BITS_NARROW;
						phase_q <= 1'b0;
						state_q <= spi_ctl_pkg::LINK_SHIFT;
					end
				end
				spi_ctl_pkg::LINK_SHIFT: begin
					if (!mst_s && ss_s) begin
						state_q <= spi_ctl_pkg::LINK_IDLE;
					end else if (tail_q) begin
						// Master data in lags one bit behind its synchroniser
						tail_q <= 1'b0;
						rx_word <= {sh_q[14:0], din};
						done_tgl <= ~done_tgl;
						state_q <= spi_ctl_pkg::LINK_IDLE;
					end else if (samp) begin
						bit_q <= din;
						phase_q <= 1'b1;
						sck_out <= mst_s;
					end else if (shft) begin
						sh_q <= {sh_q[14:0], bit_q};
						sdo <= sh_q[14];
						sck_out <= 1'b0;
						phase_q <= 1'b0;
						cnt_q <= cnt_q - 5'h01;
						if (cnt_q == 5'h01 && mst_s) begin
							tail_q <= 1'b1;
						end else if (cnt_q == 5'h01) begin
							rx_word <= {sh_q[14:0], bit_q};
							done_tgl <= ~done_tgl;
							state_q <= spi_ctl_pkg::LINK_IDLE;
						end
					end
				end
			endcase
		end
	end

endmodule

// ### hw/spi_width_and_pin_control.sv
/*
 * Width and pin control of a serial interface: control, status and data
 * registers on a byte port, pin enables, aborts and core-side crossings.
 * Assumes a one-cycle strobe register master on core_clk and a free link_clk.
 */
// Our own choice: the strobed register port.
// How it works
// - width bit picks 8-bit low byte or 16-bit high plus low data.
// - master-mode change of width, fault or pin bit aborts to idle.
// - master ignores select pin unless fault detect on and select output off, then detects faults.
// - slave always takes select pin as an input.
// - in single-wire mode output enable bit gates MOSI (master) or MISO (slave).
// - master single-wire mode: output enable change aborts to idle.
// - wait stop bit halts serial clock while in wait mode.
// - master pin use: normal MISO in MOSI out, else MOSI only.
// - slave pin use: normal MOSI in MISO out, else MISO only.
// - register readable and writable anytime; reserved bit writes ignored.
// - reserved bits read zero.
// - master with fault detect and select output drives select pin.
`timescale 1ns/1ps

module spi_width_and_pin_control (
	input wire logic core_clk, // Bus clock
	input wire logic rst_b, // Async reset, active low
	input wire logic link_clk, // Link clock
	input wire logic [2:0] reg_addr, // Register offset
	input wire logic [7:0] reg_wdata, // Write data
	input wire logic reg_wr, // Write strobe
	input wire logic reg_rd, // Read strobe
	output logic [7:0] reg_rdata, // Read data, cycle after strobe
	input wire logic wait_mode, // Processor in wait mode
	input wire logic mosi_in, // MOSI pin level
	output logic mosi_out, // MOSI drive value
	output logic mosi_oe_b, // MOSI enable, low drives
	input wire logic miso_in, // MISO pin level
	output logic miso_out, // MISO drive value
	output logic miso_oe_b, // MISO enable, low drives
	input wire logic sck_in, // SCK pin level
	output logic sck_out, // SCK drive value
	output logic sck_oe_b, // SCK enable, low drives
	input wire logic ss_in, // Select pin level
	output logic ss_out, // Select drive value
	output logic ss_oe_b // Select enable, low drives
);

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	function automatic logic masked_change(input logic [7:0] old_v, input logic [7:0] new_v,
		input logic [7:0] mask);
		masked_change = |((old_v ^ new_v) & mask);
	endfunction

	logic [7:0] ctrl_one_q;
	logic [7:0] ctrl_two_q;
	logic wr_c1;
	logic wr_c2;
	logic wr_hi;
	logic wr_lo;
	logic rd_st;
	logic rd_lo;

	assign wr_c1 = reg_wr && (reg_addr == spi_ctl_pkg::OFF_CTRL_ONE);
	assign wr_c2 = reg_wr && (reg_addr == spi_ctl_pkg::OFF_CTRL_TWO);
	assign wr_hi = reg_wr && (reg_addr == spi_ctl_pkg::OFF_DATA_HI);
	assign wr_lo = reg_wr && (reg_addr == spi_ctl_pkg::OFF_DATA_LO);
	assign rd_st = reg_rd && (reg_addr == spi_ctl_pkg::OFF_STATUS);
	assign rd_lo = reg_rd && (reg_addr == spi_ctl_pkg::OFF_DATA_LO);

	logic en;
	logic is_master;
	logic wide;
	logic fault_en;
	logic select_output_en;
	logic bidir;
	logic out_en;

	assign en = ctrl_one_q[spi_ctl_pkg::C1_ENABLE];
	assign is_master = en && ctrl_one_q[spi_ctl_pkg::C1_MASTER];
	assign wide = ctrl_two_q[spi_ctl_pkg::C2_WIDTH];
	assign fault_en = ctrl_two_q[spi_ctl_pkg::C2_FAULT];
	assign select_output_en = ctrl_one_q[spi_ctl_pkg::C1_SELECT_OUTPUT_EN];
	assign bidir = ctrl_two_q[spi_ctl_pkg::C2_BIDIR];
	assign out_en = ctrl_two_q[spi_ctl_pkg::C2_OE];

	// ------------------------------------------------------------
	// Core-side synchronisers
	// ------------------------------------------------------------
	logic done_tgl;
	logic ack_tgl;
	logic [2:0] c_meta_q;
	logic [2:0] c_sync_q;
	logic done_c;
	logic ack_c;
	logic ss_c;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			c_meta_q <= 3'h1;
			c_sync_q <= 3'h1;
		end else begin
			c_meta_q <= {done_tgl, ack_tgl, ss_in};
			c_sync_q <= c_meta_q;
		end
	end

	assign done_c = c_sync_q[2];
	assign ack_c = c_sync_q[1];
	assign ss_c = c_sync_q[0];

	// ------------------------------------------------------------
	// Abort and event detection
	// ------------------------------------------------------------
	logic busy_q;
	logic abort_pend_q;
	logic abort_tgl_q;
	logic start_tgl_q;
	logic done_seen_q;
	logic abort_c1;
	logic abort_c2;
	logic fault_evt;
	logic abort_now;
	logic done_ok;
	logic start_ok;
	logic [15:0] rx_word;

	assign abort_c2 = wr_c2 && is_master &&
		(masked_change(ctrl_two_q, reg_wdata, spi_ctl_pkg::C2_ABORT_MASK) ||
		(bidir && masked_change(ctrl_two_q, reg_wdata, spi_ctl_pkg::C2_OE_MASK)));
	assign abort_c1 = wr_c1 &&
		(masked_change(ctrl_one_q, reg_wdata, spi_ctl_pkg::C1_MASTER_MASK) ||
		masked_change(ctrl_one_q, reg_wdata, spi_ctl_pkg::C1_ENABLE_MASK) ||
		(is_master && masked_change(ctrl_one_q, reg_wdata, spi_ctl_pkg::C1_SELECT_OUTPUT_EN_MASK)));
	assign fault_evt = is_master && fault_en && !select_output_en && !ss_c;
	assign abort_now = abort_c1 || abort_c2 || fault_evt;
	assign done_ok = (done_c != done_seen_q) && !abort_pend_q && !abort_now &&
		(busy_q || !is_master);
	assign start_ok = wr_lo && en && !busy_q && !abort_pend_q && !abort_now;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			busy_q <= 1'b0;
			start_tgl_q <= 1'b0;
			done_seen_q <= 1'b0;
		end else begin
			done_seen_q <= done_c;
			if (abort_now || done_ok) begin
				busy_q <= 1'b0;
			end else if (start_ok) begin
				busy_q <= 1'b1;
				start_tgl_q <= ~start_tgl_q;
			end
		end
	end

	// One abort in flight at a time keeps the toggle slow enough to cross
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			abort_pend_q <= 1'b0;
			abort_tgl_q <= 1'b0;
		end else if (abort_now && !abort_pend_q) begin
			abort_pend_q <= 1'b1;
			abort_tgl_q <= ~abort_tgl_q;
		end else if (abort_pend_q && (ack_c == abort_tgl_q)) begin
			abort_pend_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [15:0] tx_q;
	logic [15:0] rx_q;
	logic done_flag_q;
	logic fault_q;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_one_q <= spi_ctl_pkg::CTRL_ONE_RST;
			ctrl_two_q <= spi_ctl_pkg::CTRL_TWO_RST;
		end else begin
			if (wr_c1) begin
				ctrl_one_q <= reg_wdata;
			end
			if (wr_c2) begin
				ctrl_two_q <= reg_wdata & spi_ctl_pkg::C2_IMPL_MASK;
			end
		end
	end

	// high byte only in wide mode
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_q <= 16'h0000;
			rx_q <= 16'h0000;
		end else begin
			if (wr_hi && wide && !busy_q) begin
				tx_q[15:8] <= reg_wdata;
			end
			if (start_ok) begin
				tx_q[7:0] <= reg_wdata;
			end
			if (done_ok) begin
				rx_q <= rx_word;
			end
		end
	end

	// Flags: a set in the clearing cycle wins
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			done_flag_q <= 1'b0;
			fault_q <= 1'b0;
		end else begin
			if (done_ok) begin
				done_flag_q <= 1'b1;
			end else if (rd_lo) begin
				done_flag_q <= 1'b0;
			end
			if (fault_evt) begin
				fault_q <= 1'b1;
			end else if (rd_st) begin
				fault_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			unique case (reg_addr)
				spi_ctl_pkg::OFF_CTRL_ONE: reg_rdata <= ctrl_one_q;
				spi_ctl_pkg::OFF_CTRL_TWO: reg_rdata <= ctrl_two_q;
				spi_ctl_pkg::OFF_STATUS: begin
					reg_rdata <= 8'h00;
					reg_rdata[spi_ctl_pkg::ST_DONE] <= done_flag_q;
					reg_rdata[spi_ctl_pkg::ST_EMPTY] <= !busy_q;
					reg_rdata[spi_ctl_pkg::ST_FAULT] <= fault_q;
				end
				spi_ctl_pkg::OFF_DATA_HI: reg_rdata <= wide ? rx_q[15:8] : 8'h00;
				spi_ctl_pkg::OFF_DATA_LO: reg_rdata <= rx_q[7:0];
				default: reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// ------------------------------------------------------------
	// Pin enables and link levels
	// ------------------------------------------------------------
	logic run_q;
	logic cfg_master_q;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			run_q <= 1'b1;
			cfg_master_q <= 1'b0;
		end else begin
			run_q <= !(wait_mode && ctrl_two_q[spi_ctl_pkg::C2_WAIT]);
			cfg_master_q <= is_master;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			mosi_oe_b <= 1'b1;
			miso_oe_b <= 1'b1;
			sck_oe_b <= 1'b1;
			ss_oe_b <= 1'b1;
			ss_out <= 1'b1;
		end else if (is_master) begin
			sck_oe_b <= 1'b0;
			miso_oe_b <= 1'b1;
			mosi_oe_b <= bidir ? !out_en : 1'b0;
			ss_oe_b <= !(fault_en && select_output_en);
			ss_out <= !(fault_en && select_output_en && busy_q);
		end else if (en) begin
			sck_oe_b <= 1'b1;
			ss_oe_b <= 1'b1;
			ss_out <= 1'b1;
			mosi_oe_b <= 1'b1;
			miso_oe_b <= bidir ? !out_en : ss_c;
		end else begin
			mosi_oe_b <= 1'b1;
			miso_oe_b <= 1'b1;
			sck_oe_b <= 1'b1;
			ss_oe_b <= 1'b1;
			ss_out <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Link engine
	// ------------------------------------------------------------
	logic sdo;

	spi_link_engine u_link (
		.link_clk(link_clk),
		.rst_b(rst_b),
		.start_tgl(start_tgl_q),
		.abort_tgl(abort_tgl_q),
		.run_lvl(run_q),
		.cfg_master(cfg_master_q),
		.cfg_bidir(ctrl_two_q[spi_ctl_pkg::C2_BIDIR]),
		.cfg_wide(ctrl_two_q[spi_ctl_pkg::C2_WIDTH]),
		.tx_word(tx_q),
		.mosi_in(mosi_in),
		.miso_in(miso_in),
		.sck_in(sck_in),
		.ss_in(ss_in),
		.done_tgl(done_tgl),
		.abort_ack_tgl(ack_tgl),
		.rx_word(rx_word),
		.sdo(sdo),
		.sck_out(sck_out)
	);

	assign mosi_out = sdo;
	assign miso_out = sdo;

endmodule

// ### sim/spi_peer.sv
/*
 * Serial peer in mode 0: shifts a reply MSB first, captures what it gets.
 * Assumes the master frames each word with en and idles its clock low.
 */
`timescale 1ns/1ps

module spi_peer (
	input wire logic sck, // Serial clock
	input wire logic mosi, // Data from master
	input wire logic en, // Frame active
	input wire logic [15:0] word, // Reply, MSB aligned
	output logic miso, // Data to master
	output logic [15:0] got // Captured bits
);
	logic [15:0] sh;

	always @(posedge en) begin
		sh = word;
		got = 16'h0000;
	end
	always @(posedge sck) begin
		got = {got[14:0], mosi};
	end
	always @(negedge sck) begin
		if (en) begin
			sh = {sh[14:0], ~sh[0]};
		end
	end
	// Released line shows the inverse, never a kind level
	assign miso = en ? sh[15] : ~sh[15];
endmodule

// ### sim/spi_ctl_props.sv
/*
 * Checker for register reads and pin enables of the control block.
 * Assumes it is bound to the top module and sees only its ports.
 */
`timescale 1ns/1ps

module spi_ctl_props (
	input wire logic core_clk, // Bus clock
	input wire logic rst_b, // Reset, active low
	input wire logic [2:0] reg_addr, // Offset
	input wire logic [7:0] reg_wdata, // Write data
	input wire logic reg_wr, // Write strobe
	input wire logic reg_rd, // Read strobe
	input wire logic [7:0] reg_rdata, // Read data
	input wire logic wait_mode, // Wait mode
	input wire logic mosi_oe_b, // MOSI enable
	input wire logic miso_oe_b, // MISO enable
	input wire logic sck_out, // Serial clock
	input wire logic ss_oe_b // Select enable
);
	logic [7:0] c1_q;
	logic [7:0] c2_q;
	logic [5:0] wcnt_q;
	logic mst;
	logic slv;
	logic [7:0] dif;
	logic abort_w;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	// ------------------------------------------------------------
	// Shadow of the control registers
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			c1_q <= 8'h00;
			c2_q <= 8'h00;
		end else if (reg_wr && reg_addr == 3'h0) begin
			c1_q <= reg_wdata;
		end else if (reg_wr && reg_addr == 3'h1) begin
			c2_q <= reg_wdata & spi_ctl_pkg::C2_IMPL_MASK;
		end
	end
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			wcnt_q <= 6'h00;
		end else if (!(wait_mode && c2_q[1] && mst)) begin
			wcnt_q <= 6'h00;
		end else if (wcnt_q != 6'h3f) begin
			wcnt_q <= wcnt_q + 6'h01;
		end
	end
	assign mst = c1_q[6] & c1_q[4];
	assign slv = c1_q[6] & ~c1_q[4];
	assign dif = reg_wdata ^ c2_q;
	assign abort_w = reg_wr && reg_addr == 3'h1 && mst
		&& ((dif & spi_ctl_pkg::C2_ABORT_MASK) != 8'h00 || (c2_q[0] && dif[3]));

	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	a_ctrl2_read: assert property (
		reg_rd && reg_addr == 3'h1 |=> reg_rdata == $past(c2_q))
		else $error("control two read back wrong");
	a_rsvd_addr: assert property (
		reg_rd && reg_addr[2:1] == 2'b11 |=> reg_rdata == 8'h00)
		else $error("reserved offset not zero");
	a_mosi_enable: assert property (
		(mst && $stable(c2_q)) [*3] |-> mosi_oe_b == (c2_q[0] & ~c2_q[3]))
		else $error("master MOSI enable wrong");
	a_miso_master: assert property (
		mst [*3] |-> miso_oe_b)
		else $error("master drives MISO");
	a_slave_pins: assert property (
		slv [*3] |-> mosi_oe_b && ss_oe_b)
		else $error("slave drives MOSI or select");
	a_ss_output: assert property (
		(mst && c2_q[4] && c1_q[1]) [*3] |-> !ss_oe_b)
		else $error("select output not driven");
	a_ss_unused: assert property (
		(mst && !(c2_q[4] && c1_q[1])) [*3] |-> ss_oe_b)
		else $error("select driven while unused");
	a_abort_idle: assert property (
		abort_w ##2 (reg_rd && reg_addr == 3'h3) |=> reg_rdata[5])
		else $error("busy after abort");
	a_wait_sck: assert property (
		wcnt_q == 6'h3f |-> $stable(sck_out))
		else $error("serial clock runs in wait");

	c_abort: cover property (abort_w);
	c_wait: cover property (wcnt_q == 6'h3f);
	c_data: cover property (reg_rd && reg_addr == 3'h5);
endmodule

bind spi_width_and_pin_control spi_ctl_props u_spi_ctl_props (
	.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .wait_mode(wait_mode), .mosi_oe_b(mosi_oe_b),
	.miso_oe_b(miso_oe_b), .sck_out(sck_out), .ss_oe_b(ss_oe_b)
);

// ### sim/tb.sv
/*
 * Bench for the control block: registers, transfers, aborts, pins, wait.
 * Assumes the checker is bound and the peer model sits on the pins.
 */
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin mismatches++; \
	$display("Error %0t: mismatch at line %0d", $time, `__LINE__); end end

module tb;
	logic core_clk, link_clk, rst_b, reg_wr, reg_rd, wait_mode;
	logic [2:0] reg_addr;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic mosi_out, mosi_oe_b, miso_out, miso_oe_b, sck_out, sck_oe_b;
	logic ss_out, ss_oe_b, mosi_w, miso_w, sck_w, ss_w, p_miso, frame, tb_ss;
	logic [15:0] p_word;
	logic [15:0] p_got;
	int mismatches;
	int checked;
	int cyc;

	assign mosi_w = !mosi_oe_b ? mosi_out : ~mosi_out;
	assign miso_w = !miso_oe_b ? miso_out : p_miso;
	assign sck_w = !sck_oe_b ? sck_out : 1'b0;
	assign ss_w = !ss_oe_b ? ss_out : tb_ss;

	spi_width_and_pin_control u_spi_width_and_pin_control (
		.core_clk(core_clk), .rst_b(rst_b), .link_clk(link_clk),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .wait_mode(wait_mode),
		.mosi_in(mosi_w), .mosi_out(mosi_out), .mosi_oe_b(mosi_oe_b),
		.miso_in(miso_w), .miso_out(miso_out), .miso_oe_b(miso_oe_b),
		.sck_in(sck_w), .sck_out(sck_out), .sck_oe_b(sck_oe_b),
		.ss_in(ss_w), .ss_out(ss_out), .ss_oe_b(ss_oe_b)
	);
	spi_peer u_spi_peer (.sck(sck_w), .mosi(mosi_w), .en(frame),
		.word(p_word), .miso(p_miso), .got(p_got));

	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	initial begin
		link_clk = 1'b0;
		#3;
		forever #40 link_clk = ~link_clk;
	end

	task automatic end_sim();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			end_sim();
		end
	end

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask
	// Mode changes abort and block starts until the link answers
	task automatic cfg(input logic [7:0] c1, input logic [7:0] c2);
		wr(3'h0, c1);
		wr(3'h1, c2);
		repeat (12) @(posedge link_clk);
	endtask
	task automatic settle();
		repeat (8) @(posedge core_clk);
		#1;
	endtask
	task automatic wait_done();
		logic [7:0] s;
		int n;
		s = 8'h00;
		n = 0;
		while (s[7] !== 1'b1 && n < 400) begin
			rd(3'h3, s);
			n++;
		end
		`CHK(s[7], 1'b1)
	endtask

	task automatic t_regs();
		logic [7:0] d;
		rd(3'h1, d);
		`CHK(d, 8'h00)
		wr(3'h1, 8'hff);
		rd(3'h1, d);
		`CHK(d, 8'h5b)
		rd(3'h6, d);
		`CHK(d, 8'h00)
		wr(3'h1, 8'h00);
		$display("registers done");
	endtask
	task automatic t_xfer(input logic wide, input logic [15:0] tx, input logic [15:0] rx);
		logic [7:0] d;
		cfg(8'h50, {1'b0, wide, 6'h00});
		p_word <= wide ? rx : {rx[7:0], 8'h00};
		frame <= 1'b1;
		if (wide) begin
			wr(3'h4, tx[15:8]);
		end
		wr(3'h5, tx[7:0]);
		settle();
		`CHK(mosi_oe_b, 1'b0)
		`CHK(miso_oe_b, 1'b1)
		wait_done();
		frame <= 1'b0;
		rd(3'h5, d);
		`CHK(d, rx[7:0])
		rd(3'h4, d);
		`CHK(d, wide ? rx[15:8] : 8'h00)
		`CHK(wide ? p_got : {8'h00, p_got[7:0]}, wide ? tx : {8'h00, tx[7:0]})
		$display("transfer done");
	endtask
	task automatic t_abort();
		logic [7:0] s;
		cfg(8'h50, 8'h40);
		wr(3'h4, 8'hc3);
		wr(3'h5, 8'h5a);
		rd(3'h3, s);
		`CHK(s[5], 1'b0)
		wr(3'h1, 8'h00);
		rd(3'h3, s);
		`CHK(s[5], 1'b1)
		cfg(8'h50, 8'h01);
		wr(3'h5, 8'h77);
		rd(3'h3, s);
		`CHK(s[5], 1'b0)
		wr(3'h1, 8'h09);
		rd(3'h3, s);
		`CHK(s[5], 1'b1)
		repeat (12) @(posedge link_clk);
		$display("abort done");
	endtask
	task automatic t_pins();
		cfg(8'h50, 8'h01);
		`CHK(mosi_oe_b, 1'b1)
		`CHK(miso_oe_b, 1'b1)
		cfg(8'h50, 8'h09);
		`CHK(mosi_oe_b, 1'b0)
		cfg(8'h40, 8'h00);
		`CHK(mosi_oe_b, 1'b1)
		`CHK(miso_oe_b, 1'b1)
		tb_ss <= 1'b0;
		settle();
		`CHK(miso_oe_b, 1'b0)
		cfg(8'h42, 8'h19);
		`CHK(ss_oe_b, 1'b1)
		`CHK(miso_oe_b, 1'b0)
		`CHK(mosi_oe_b, 1'b1)
		tb_ss <= 1'b1;
		$display("pins done");
	endtask
	task automatic t_ss();
		logic [7:0] s;
		cfg(8'h52, 8'h10);
		`CHK(ss_oe_b, 1'b0)
		wr(3'h5, 8'h3c);
		settle();
		`CHK(ss_out, 1'b0)
		wait_done();
		`CHK(ss_out, 1'b1)
		rd(3'h5, s);
		cfg(8'h50, 8'h00);
		`CHK(ss_oe_b, 1'b1)
		cfg(8'h50, 8'h10);
		tb_ss <= 1'b0;
		settle();
		tb_ss <= 1'b1;
		settle();
		rd(3'h3, s);
		`CHK(s[4], 1'b1)
		rd(3'h3, s);
		`CHK(s[4], 1'b0)
		$display("select done");
	endtask
	task automatic t_wait();
		logic [7:0] s;
		logic b;
		cfg(8'h50, 8'h02);
		@(posedge core_clk);
		wait_mode <= 1'b1;
		p_word <= 16'h9600;
		frame <= 1'b1;
		wr(3'h5, 8'h69);
		repeat (100) @(posedge core_clk);
		#1;
		b = sck_out;
		repeat (50) @(posedge core_clk);
		#1;
		`CHK(sck_out, b)
		rd(3'h3, s);
		`CHK(s[5], 1'b0)
		@(posedge core_clk);
		wait_mode <= 1'b0;
		wait_done();
		rd(3'h5, s);
		`CHK(s, 8'h96)
		frame <= 1'b0;
		$display("wait done");
	endtask

	initial begin
		rst_b = 1'b0;
		reg_addr = 3'h0;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		wait_mode = 1'b0;
		tb_ss = 1'b1;
		frame = 1'b0;
		p_word = 16'h0000;
		mismatches = 0;
		checked = 0;
		cyc = 0;
		repeat (16) @(posedge core_clk);
		rst_b <= 1'b1;
		t_regs();
		t_xfer(1'b0, 16'h00a5, 16'h003c);
		t_xfer(1'b1, 16'h1234, 16'hbeef);
		t_abort();
		t_pins();
		t_ss();
		t_wait();
		end_sim();
	end
endmodule
